// [dv/trlc_tb.sv]
// self-checking bench for the trim and rate limit configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // clock, reset and design ports
  // ---------------------------------------------------------------
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    cyc   = 1'b0;
  logic                    stb   = 1'b0;
  logic                    we    = 1'b0;
  logic             [31:0] adr   = '0;
  logic             [31:0] wdat  = '0;
  logic             [3:0]  sel   = '0;
  logic                    sv    = 1'b0;
  logic             [9:0]  raw   = '0;
  logic                    rv    = 1'b0;
  logic signed      [8:0]  dev   = '0;
  logic             [31:0] rdat;
  logic                    ack;
  logic             [4:0]  cpf;
  logic                    f5, f2, f1, f0, bufe, rs, rt, rh, scv, rcv, racc;
  logic signed      [12:0] sc;
  int                      n_mismatch = 0;
  int                      comparisons = 0;
  int                      cyc_cnt = 0;
  logic             [7:0]  regs_m [256];
  logic             [31:0] rd_q [$];
  logic signed      [12:0] sc_q [$];
  logic                    ra_q [$];
  logic             [7:0]  idx_l [9] = '{trlc_pkg::IDX_COARSE,
    trlc_pkg::IDX_FINE, trlc_pkg::IDX_MON, trlc_pkg::IDX_CONV,
    trlc_pkg::IDX_OFFS, trlc_pkg::IDX_SLOPE, trlc_pkg::IDX_UPPER,
    trlc_pkg::IDX_LOWER, trlc_pkg::IDX_RCFG};

  always #5 clk_i = ~clk_i;

  trlc_top u_trlc_top (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .coarse_cap_pf_o(cpf), .fine_trim_500ff_o(f5),
    .fine_trim_250ff_o(f2), .fine_trim_125ff_o(f1),
    .fine_trim_62ff_o(f0), .strength_buffer_enable_o(bufe),
    .conv_route_strength_o(rs), .conv_route_temp_o(rt),
    .conv_route_half_supply_o(rh), .strength_valid_i(sv),
    .strength_raw_i(raw), .strength_comp_valid_o(scv),
    .strength_comp_o(sc), .rate_dev_valid_i(rv), .rate_dev_i(dev),
    .rate_check_valid_o(rcv), .rate_accept_o(racc)
  );

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic finish_test;
    // an expected result that never showed up is a mismatch too
    if (rd_q.size() + sc_q.size() + ra_q.size() != 0) n_mismatch++;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one compare per kind of result, all counted by chk
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    chk(g, e);
  endtask

  task automatic chk_pins(input logic [12:0] g, input logic [12:0] e);
    chk({19'h0_0000, g}, {19'h0_0000, e});
  endtask

  task automatic chk_comp(input logic signed [12:0] g,
                          input logic signed [12:0] e);
    chk(32'(g), 32'(e));
  endtask

  task automatic chk_rate(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  function automatic logic [7:0] msk(input logic [7:0] i);
    case (i)
      trlc_pkg::IDX_COARSE: return 8'h1f;
      trlc_pkg::IDX_FINE: return 8'h0f;
      trlc_pkg::IDX_MON, trlc_pkg::IDX_RCFG: return 8'h01;
      trlc_pkg::IDX_CONV: return 8'h07;
      default: return 8'hff;
    endcase
  endfunction

  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h00_0000, i, 2'b00};
  endfunction

  // results are compared in the order in which they were requested
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) chk_reg(rdat, rd_q.pop_front());
    if (scv === 1'b1) chk_comp(sc, sc_q.pop_front());
    if (rcv === 1'b1) chk_rate(racc, ra_q.pop_front());
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // request held until ack is sampled, released at that edge
  task automatic wb(input logic w, input logic [31:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // no limit here: a slave that never answers ends at the bench timeout
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    wb(1'b1, ad(i), {24'h00_0000, d}, 4'h1);
    regs_m[i] = d & msk(i);
  endtask

  task automatic rd(input logic [7:0] i);
    rd_q.push_back({24'h00_0000, regs_m[i]});
    wb(1'b0, ad(i), '0, 4'hf);
  endtask

  // config pins settle one cycle after the write edge
  task automatic cfg_chk;
    logic [7:0]  c;
    logic [2:0]  v;
    logic [12:0] e;
    c = regs_m[trlc_pkg::IDX_COARSE];
    v = regs_m[trlc_pkg::IDX_CONV][2:0];
    e = {(c[4:0] > trlc_pkg::COARSE_MAX) ? trlc_pkg::COARSE_MAX : c[4:0],
         regs_m[trlc_pkg::IDX_FINE][3:0],
         regs_m[trlc_pkg::IDX_MON][0], v == 3'h0, v == 3'h1, v == 3'h2};
    repeat (2) @(posedge clk_i);
    chk_pins({cpf, f5, f2, f1, f0, bufe, rs, rt, rh}, e);
  endtask

  task automatic smp(input logic [9:0] r);
    int e;
    e = ((int'(r) * int'(regs_m[trlc_pkg::IDX_SLOPE])) >>> 7)
        + 2 * int'(regs_m[trlc_pkg::IDX_OFFS]) - 256;
    sv <= 1'b1;
    raw <= r;
    sc_q.push_back(13'(e));
    @(posedge clk_i);
  endtask

  task automatic rsm(input int d);
    int up;
    int lo;
    up = int'(regs_m[trlc_pkg::IDX_UPPER]);
    lo = int'(regs_m[trlc_pkg::IDX_LOWER]);
    rv <= 1'b1;
    dev <= 9'(d);
    ra_q.push_back(regs_m[trlc_pkg::IDX_RCFG][0] ? (d >= -lo && d <= up) : 1'b1);
    @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h2b6984dc));
    regs_m[trlc_pkg::IDX_COARSE] = {3'h0, trlc_pkg::RST_COARSE};
    regs_m[trlc_pkg::IDX_FINE] = {4'h0, trlc_pkg::RST_FINE};
    regs_m[trlc_pkg::IDX_MON] = {7'h00, trlc_pkg::RST_MON};
    regs_m[trlc_pkg::IDX_CONV] = {5'h00, trlc_pkg::RST_CONV};
    regs_m[trlc_pkg::IDX_OFFS] = trlc_pkg::RST_OFFS;
    regs_m[trlc_pkg::IDX_SLOPE] = trlc_pkg::RST_SLOPE;
    regs_m[trlc_pkg::IDX_UPPER] = trlc_pkg::RST_UPPER;
    regs_m[trlc_pkg::IDX_LOWER] = trlc_pkg::RST_LOWER;
    regs_m[trlc_pkg::IDX_RCFG] = {7'h00, trlc_pkg::RST_RCFG};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg_chk;
    chk_rate(racc, 1'b1);
    foreach (idx_l[k]) rd(idx_l[k]);
    foreach (idx_l[k]) begin
      wr(idx_l[k], 8'hff);
      rd(idx_l[k]);
      wr(idx_l[k], 8'($urandom));
      rd(idx_l[k]);
    end
    wb(1'b1, ad(trlc_pkg::IDX_COARSE), 32'h0000_0005, 4'h0);
    wb(1'b1, ad(trlc_pkg::IDX_COARSE) | 32'h0001_0000, '1, 4'hf);
    rd(trlc_pkg::IDX_COARSE);
    rd_q.push_back('0);
    wb(1'b0, ad(trlc_pkg::IDX_UPPER) | 32'h0001_0000, '0, 4'hf);
    for (int i = 0; i < 32; i++) begin
      wr(trlc_pkg::IDX_COARSE, 8'(i));
      wr(trlc_pkg::IDX_FINE, 8'(i ^ 32'h0000_00f0));
      wr(trlc_pkg::IDX_MON, 8'(i + 1));
      wr(trlc_pkg::IDX_CONV, 8'(i));
      cfg_chk;
    end
    // status after the last code: coarse clamped, accept still reset, code unused
    rd_q.push_back({24'h00_0000, 3'b001, trlc_pkg::COARSE_MAX});
    wb(1'b0, ad(trlc_pkg::IDX_STAT), '0, 4'hf);
    // extremes and random, back to back
    for (int j = 0; j < 4; j++) begin
      wr(trlc_pkg::IDX_OFFS, j == 0 ? 8'h00 : j == 1 ? 8'hff : 8'($urandom));
      wr(trlc_pkg::IDX_SLOPE, j == 0 ? 8'h00 : j == 1 ? 8'hff : 8'($urandom));
      smp(10'h000);
      smp(10'h3ff);
      repeat (6) smp(10'($urandom));
      sv <= 1'b0;
    end
    wr(trlc_pkg::IDX_RCFG, 8'h00);
    rsm(-256);
    rsm(255);
    rv <= 1'b0;
    wr(trlc_pkg::IDX_RCFG, 8'hff);
    for (int j = 0; j < 6; j++) begin
      wr(trlc_pkg::IDX_UPPER, j == 0 ? 8'h00 : 8'($urandom % 200));
      wr(trlc_pkg::IDX_LOWER, j == 0 ? 8'h00 : 8'($urandom % 200));
      rsm(int'(regs_m[trlc_pkg::IDX_UPPER]));
      rsm(int'(regs_m[trlc_pkg::IDX_UPPER]) + 1);
      rsm(-int'(regs_m[trlc_pkg::IDX_LOWER]));
      rsm(-int'(regs_m[trlc_pkg::IDX_LOWER]) - 1);
      rsm(int'($urandom % 512) - 256);
      rv <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    finish_test;
  end
endmodule
`default_nettype wire

// [rtl/trlc_field.sv]
// one writable configuration field with reset value
`timescale 1ns/1ps
`default_nettype none
module trlc_field #(
  parameter int unsigned W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // write port
  input  wire logic         we_i,
  input  wire logic [W-1:0] d_i,
  // stored value
  output logic      [W-1:0] q_o
);

  logic [W-1:0] val_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      val_q <= RST;
    end else if (we_i) begin
      val_q <= d_i;
    end
  end

  assign q_o = val_q;

endmodule
`default_nettype wire

// [rtl/trlc_pkg.sv]
// constants for the trim and rate limit configuration bank
package trlc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_COARSE = 8'h8c;
  localparam logic [7:0] IDX_FINE   = 8'h8d;
  localparam logic [7:0] IDX_MON    = 8'h8e;
  localparam logic [7:0] IDX_CONV   = 8'h8f;
  localparam logic [7:0] IDX_OFFS   = 8'h90;
  localparam logic [7:0] IDX_SLOPE  = 8'h91;
  localparam logic [7:0] IDX_UPPER  = 8'h92;
  localparam logic [7:0] IDX_LOWER  = 8'h93;
  localparam logic [7:0] IDX_RCFG   = 8'ha0;
  localparam logic [7:0] IDX_STAT   = 8'ha1;

  // ---------------------------------------------------------------
  // field widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned COARSE_W = 5;
  localparam int unsigned FINE_W   = 4;
  localparam int unsigned CONV_W   = 3;
  localparam logic [4:0] RST_COARSE = 5'h10;
  localparam logic [3:0] RST_FINE   = 4'h0;
  localparam logic [0:0] RST_MON    = 1'h1;
  localparam logic [2:0] RST_CONV   = 3'h0;
  localparam logic [7:0] RST_OFFS   = 8'h80;
  localparam logic [7:0] RST_SLOPE  = 8'h80;
  localparam logic [7:0] RST_UPPER  = 8'h1e;
  localparam logic [7:0] RST_LOWER  = 8'h23;
  localparam logic [0:0] RST_RCFG   = 1'h0;

  // ---------------------------------------------------------------
  // field positions and scaling
  // ---------------------------------------------------------------
  localparam int unsigned FINE_500_BIT = 3;
  localparam int unsigned FINE_250_BIT = 2;
  localparam int unsigned FINE_125_BIT = 1;
  localparam int unsigned FINE_62_BIT  = 0;
  localparam int unsigned STAT_ACC_BIT = 5;
  localparam int unsigned STAT_SRC_BIT = 6;
  localparam logic [4:0]  COARSE_MAX   = 5'h18;
  localparam int unsigned SLOPE_SHIFT  = 7;
  localparam logic signed [12:0] OFFS_BIAS = 13'sh0100;

  typedef enum logic [2:0] {
    SRC_STRENGTH    = 3'b000,
    SRC_TEMP        = 3'b001,
    SRC_HALF_SUPPLY = 3'b010
  } trlc_src_e;

endpackage

// [rtl/trlc_top.sv]
// trim, strength compensation and rate limit configuration bank
// What this block does
// - five-bit coarse trim selects 1 pF per step, 0 to 24 pF
// - coarse codes above 18h clamp to 24 pF
// - four fine trim bits each connect one binary-weighted capacitor
// - monitor buffer driven only while its enable bit is one, reset one
// - three-bit code routes strength, temperature or half supply
// - offset code maps to signed correction from -256 to 254
// - strength result multiplied by slope code times two to minus seven
// - eight-bit upper threshold bounds faster rates, reset near ten percent
// - eight-bit lower threshold, reset 23h, bounds slower rates
// - thresholds act only while rate limit enable is set
// - larger threshold code always accepts larger deviation
`timescale 1ns/1ps
`default_nettype none
module trlc_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // crystal trim
  output logic      [4:0]  coarse_cap_pf_o,
  output logic             fine_trim_500ff_o,
  output logic             fine_trim_250ff_o,
  output logic             fine_trim_125ff_o,
  output logic             fine_trim_62ff_o,
  // monitor pin buffer and converter routing
  output logic             strength_buffer_enable_o,
  output logic             conv_route_strength_o,
  output logic             conv_route_temp_o,
  output logic             conv_route_half_supply_o,
  // strength compensation
  input  wire logic        strength_valid_i,
  input  wire logic [9:0]  strength_raw_i,
  output logic             strength_comp_valid_o,
  output logic signed [12:0] strength_comp_o,
  // data rate acceptance
  input  wire logic        rate_dev_valid_i,
  input  wire logic signed [8:0] rate_dev_i,
  output logic             rate_check_valid_o,
  output logic             rate_accept_o
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic       ack_q;
  logic [7:0] rd_q;
  wire  [7:0] idx    = adr_i[9:2];
  wire        hi_zero = (adr_i[31:10] == 22'h00_0000);
  wire        req    = cyc_i & stb_i;
  // writes land on the edge where the master sees ack
  wire        wr     = req & we_i & ack_q & sel_i[0] & hi_zero;
  wire  [7:0] wd     = dat_i[7:0];

  wire we_coarse = wr & (idx == trlc_pkg::IDX_COARSE);
  wire we_fine   = wr & (idx == trlc_pkg::IDX_FINE);
  wire we_mon    = wr & (idx == trlc_pkg::IDX_MON);
  wire we_conv   = wr & (idx == trlc_pkg::IDX_CONV);
  wire we_offs   = wr & (idx == trlc_pkg::IDX_OFFS);
  wire we_slope  = wr & (idx == trlc_pkg::IDX_SLOPE);
  wire we_upper  = wr & (idx == trlc_pkg::IDX_UPPER);
  wire we_lower  = wr & (idx == trlc_pkg::IDX_LOWER);
  wire we_rcfg   = wr & (idx == trlc_pkg::IDX_RCFG);

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  logic [4:0] coarse_q;
  logic [3:0] fine_q;
  logic [0:0] mon_q;
  logic [2:0] conv_q;
  logic [7:0] offs_q;
  logic [7:0] slope_q;
  logic [7:0] upper_q;
  logic [7:0] lower_q;
  logic [0:0] rcfg_q;

  trlc_field #(.W(5), .RST(trlc_pkg::RST_COARSE)) u_coarse (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_coarse),
    .d_i (wd[4:0]), .q_o (coarse_q));
  trlc_field #(.W(4), .RST(trlc_pkg::RST_FINE)) u_fine (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_fine),
    .d_i (wd[3:0]), .q_o (fine_q));
  trlc_field #(.W(1), .RST(trlc_pkg::RST_MON)) u_mon (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_mon),
    .d_i (wd[0:0]), .q_o (mon_q));
  trlc_field #(.W(3), .RST(trlc_pkg::RST_CONV)) u_conv (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_conv),
    .d_i (wd[2:0]), .q_o (conv_q));
  trlc_field #(.W(8), .RST(trlc_pkg::RST_OFFS)) u_offs (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_offs),
    .d_i (wd), .q_o (offs_q));
  trlc_field #(.W(8), .RST(trlc_pkg::RST_SLOPE)) u_slope (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_slope),
    .d_i (wd), .q_o (slope_q));
  trlc_field #(.W(8), .RST(trlc_pkg::RST_UPPER)) u_upper (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_upper),
    .d_i (wd), .q_o (upper_q));
  trlc_field #(.W(8), .RST(trlc_pkg::RST_LOWER)) u_lower (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_lower),
    .d_i (wd), .q_o (lower_q));
  trlc_field #(.W(1), .RST(trlc_pkg::RST_RCFG)) u_rcfg (
    .clk_i (clk_i), .rst_i (rst_i), .we_i (we_rcfg),
    .d_i (wd[0:0]), .q_o (rcfg_q));

  // ---------------------------------------------------------------
  // crystal trim and routing
  // ---------------------------------------------------------------
  // clamp instead of wrapping
  wire [4:0] coarse_eff = (coarse_q > trlc_pkg::COARSE_MAX) ?
                          trlc_pkg::COARSE_MAX : coarse_q;
  wire src_str  = (conv_q == 3'(trlc_pkg::SRC_STRENGTH));
  wire src_tmp  = (conv_q == 3'(trlc_pkg::SRC_TEMP));
  wire src_half = (conv_q == 3'(trlc_pkg::SRC_HALF_SUPPLY));
  wire src_ok   = src_str | src_tmp | src_half;

  logic [4:0] coarse_pf_q;
  logic [3:0] fine_out_q;
  logic       mon_out_q;
  logic [2:0] route_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coarse_pf_q <= trlc_pkg::RST_COARSE;
      fine_out_q  <= trlc_pkg::RST_FINE;
      mon_out_q   <= trlc_pkg::RST_MON[0];
      route_q     <= 3'h1;
    end else begin
      coarse_pf_q <= coarse_eff;
      fine_out_q  <= fine_q;
      mon_out_q   <= mon_q[0];
      route_q     <= {src_half, src_tmp, src_str};
    end
  end

  assign coarse_cap_pf_o          = coarse_pf_q;
  assign fine_trim_500ff_o        = fine_out_q[trlc_pkg::FINE_500_BIT];
  assign fine_trim_250ff_o        = fine_out_q[trlc_pkg::FINE_250_BIT];
  assign fine_trim_125ff_o        = fine_out_q[trlc_pkg::FINE_125_BIT];
  assign fine_trim_62ff_o         = fine_out_q[trlc_pkg::FINE_62_BIT];
  assign strength_buffer_enable_o = mon_out_q;
  assign conv_route_strength_o    = route_q[0];
  assign conv_route_temp_o        = route_q[1];
  assign conv_route_half_supply_o = route_q[2];

  // ---------------------------------------------------------------
  // strength compensation
  // ---------------------------------------------------------------
  // slope first, then offset, so the offset is not scaled
  // product shifted by seven
  wire [17:0] prod   = strength_raw_i * slope_q;
  wire [10:0] scaled = prod[17:trlc_pkg::SLOPE_SHIFT];
  wire signed [12:0] offs_s = $signed({4'h0, offs_q, 1'b0})
                              - trlc_pkg::OFFS_BIAS;
  wire signed [12:0] comp = $signed({2'b00, scaled}) + offs_s;

  logic              comp_vld_q;
  logic signed [12:0] comp_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_vld_q <= 1'b0;
      comp_q     <= 13'sh0000;
    end else begin
      comp_vld_q <= strength_valid_i;
      if (strength_valid_i) begin
        comp_q <= comp;
      end
    end
  end

  assign strength_comp_valid_o = comp_vld_q;
  assign strength_comp_o       = comp_q;

  // ---------------------------------------------------------------
  // data rate acceptance
  // ---------------------------------------------------------------
  // window grows with each code
  wire signed [9:0] dev_x  = {rate_dev_i[8], rate_dev_i};
  wire signed [9:0] up_x   = $signed({2'b00, upper_q});
  wire signed [9:0] lo_x   = -$signed({2'b00, lower_q});
  wire              in_win = (dev_x <= up_x) && (dev_x >= lo_x);
  wire              accept = ~rcfg_q[0] | in_win;

  logic acc_vld_q;
  logic acc_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_vld_q <= 1'b0;
      acc_q     <= 1'b1;
    end else begin
      acc_vld_q <= rate_dev_valid_i;
      if (rate_dev_valid_i) begin
        acc_q <= accept;
      end
    end
  end

  assign rate_check_valid_o = acc_vld_q;
  assign rate_accept_o      = acc_q;

  // ---------------------------------------------------------------
  // read mux and acknowledge
  // ---------------------------------------------------------------
  // unused and unmapped read as zero
  wire [7:0] stat = {1'b0, src_ok, acc_q, coarse_eff};
  wire [7:0] rdata =
    !hi_zero                       ? 8'h00 :
    (idx == trlc_pkg::IDX_COARSE)  ? {3'h0, coarse_q} :
    (idx == trlc_pkg::IDX_FINE)    ? {4'h0, fine_q} :
    (idx == trlc_pkg::IDX_MON)     ? {7'h00, mon_q} :
    (idx == trlc_pkg::IDX_CONV)    ? {5'h00, conv_q} :
    (idx == trlc_pkg::IDX_OFFS)    ? offs_q :
    (idx == trlc_pkg::IDX_SLOPE)   ? slope_q :
    (idx == trlc_pkg::IDX_UPPER)   ? upper_q :
    (idx == trlc_pkg::IDX_LOWER)   ? lower_q :
    (idx == trlc_pkg::IDX_RCFG)    ? {7'h00, rcfg_q} :
    (idx == trlc_pkg::IDX_STAT)    ? stat : 8'h00;

  // one wait state; unmapped addresses still get ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rd_q  <= 8'h00;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rd_q <= rdata;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = {24'h00_0000, rd_q};

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_new;
    req && !ack_q;
  endsequence
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  property p_ack_timing;
    s_req_new |=> s_ack_pulse;
  endproperty
  a_ack_timing: assert property (p_ack_timing)
    else $error("ack not one cycle after request");

  property p_coarse_clamp;
    (coarse_q > trlc_pkg::COARSE_MAX) |=>
      (coarse_cap_pf_o == trlc_pkg::COARSE_MAX);
  endproperty
  a_coarse_clamp: assert property (p_coarse_clamp)
    else $error("coarse trim not clamped to 24 pF");

  property p_coarse_pass;
    (coarse_q <= trlc_pkg::COARSE_MAX) |=>
      (coarse_cap_pf_o == $past(coarse_q));
  endproperty
  a_coarse_pass: assert property (p_coarse_pass)
    else $error("coarse trim not passed through");

  property p_fine_bits;
    ##1 {fine_trim_500ff_o, fine_trim_250ff_o, fine_trim_125ff_o,
         fine_trim_62ff_o} == $past(fine_q);
  endproperty
  a_fine_bits: assert property (p_fine_bits)
    else $error("fine trim bits mismatch");

  property p_mon_write;
    // both polarities: a buffer stuck on must fail as well
    we_mon ##1 1'b1 |=> (strength_buffer_enable_o == $past(wd[0], 2));
  endproperty
  a_mon_write: assert property (p_mon_write)
    else $error("buffer enable does not follow written bit");

  property p_route;
    (conv_q > 3'(trlc_pkg::SRC_HALF_SUPPLY)) |=> (route_q == 3'h0);
  endproperty
  a_route: assert property (p_route)
    else $error("unused converter code routed a source");

  property p_comp;
    strength_valid_i |=> strength_comp_valid_o &&
      (strength_comp_o == $past(comp));
  endproperty
  a_comp: assert property (p_comp)
    else $error("compensated strength not captured");

  property p_offs_zero;
    (strength_valid_i && slope_q == 8'h00 && offs_q == 8'h00)
      |=> (strength_comp_o == -13'sd256);
  endproperty
  a_offs_zero: assert property (p_offs_zero)
    else $error("offset code zero not -256");

  property p_rate_off;
    (rate_dev_valid_i && !rcfg_q[0]) |=> rate_accept_o;
  endproperty
  a_rate_off: assert property (p_rate_off)
    else $error("rejection while limit disabled");

  property p_rate_high;
    (rate_dev_valid_i && rcfg_q[0] && dev_x > up_x) |=> !rate_accept_o;
  endproperty
  a_rate_high: assert property (p_rate_high)
    else $error("too fast rate accepted");

  property p_rate_low;
    (rate_dev_valid_i && rcfg_q[0] && dev_x < lo_x) |=> !rate_accept_o;
  endproperty
  a_rate_low: assert property (p_rate_low)
    else $error("too slow rate accepted");

  property p_rate_zero;
    (rate_dev_valid_i && rate_dev_i == 9'sd0) |=> rate_accept_o;
  endproperty
  a_rate_zero: assert property (p_rate_zero)
    else $error("nominal rate rejected");

  property p_unused_zero;
    (req && !ack_q && idx == trlc_pkg::IDX_FINE) |=>
      (dat_o[31:4] == 28'h0);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bits read non-zero");

endmodule
`default_nettype wire
